// ==== pxm_pkg.sv ====
// Constants shared by the port and external-bus pin multiplexer.
// Assumes a single machine clock and synchronous, active-high reset.
package pxm_pkg;

  // Pin counts of the port groups, and the counter width
  localparam int GRP0_W = 8;
  localparam int GRP1_W = 7;
  localparam int GRP3_W = 7;
  localparam int CNT_W  = 16;

  // Group 1 pin positions
  localparam int G1_TMR_OUT = 1;
  localparam int G1_SER_OUT = 3;
  localparam int G1_SER_CLK = 4;
  localparam int G1_SER_IN  = 2;
  localparam int G1_TMR_IN  = 0;

  // Group 3 pin positions
  localparam int G3_ALE  = 0;
  localparam int G3_RD   = 1;
  localparam int G3_WRL  = 2;
  localparam int G3_WRH  = 3;
  localparam int G3_HRQ  = 4;
  localparam int G3_HAK  = 5;
  localparam int G3_RDY  = 6;
  localparam int G3_CMP0 = 4;

  // Capture edge selection codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Reset values
  localparam logic [7:0]  RST_PIN    = 8'h00;
  localparam logic [15:0] RST_CNT    = 16'h0000;
  localparam logic        RST_STROBE = 1'b1;

endpackage : pxm_pkg

// ==== pxm_pin_mux.sv ====
// Pin multiplexer for port groups 0, 1 and 3: GPIO, external bus, peripherals.
// Assumes bus controller, timer, serial and compare units sit beside it on
// clk_sys; pad inputs are already synchronous to clk_sys.
// How it works
// RULE1: Single-chip pins are GPIO with switchable pull-up
// RULE2: Bus mode: group 0 carries bus bits 0-7
// RULE3: Bus mode: group 1 pins carry bits 8-14
// RULE4: Bus mode: group 3 pin 0 is address latch
// RULE5: Bus mode: group 3 pin 1 is read strobe
// RULE6: Pin 3.2 write strobe needs bus and enable
// RULE7: Shared strobe writes low byte or byte
// RULE8: Pin 3.3 high strobe needs bus, 16-bit, enable
// RULE9: Hold request honoured only with bus and hold
// RULE10: Pin 3.5 hold acknowledge needs bus and hold
// RULE11: Pin 3.6 ready input needs bus and ready
// RULE12: Group 0 and two pins feed interrupt inputs
// RULE13: Pins 1.0 and 1.1 serve reload timer 1
// RULE14: Pins 1.2 to 1.4 serve serial channel 3
// RULE15: Group 3 pins feed capture, compare channels
// RULE16: Capture latches free-run count on chosen edge
// RULE17: Bus ownership overrides GPIO direction and data
`timescale 1ns/100ps
module pxm_pin_mux (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Pads
  input  wire logic [7:0]  port_grp0_pins_in,
  output      logic [7:0]  port_grp0_pins_out,
  output      logic [7:0]  port_grp0_pins_oe,
  output      logic [7:0]  port_grp0_pins_pullup,
  input  wire logic [6:0]  port_grp1_pins_in,
  output      logic [6:0]  port_grp1_pins_out,
  output      logic [6:0]  port_grp1_pins_oe,
  output      logic [6:0]  port_grp1_pins_pullup,
  input  wire logic [6:0]  port_grp3_pins_in,
  output      logic [6:0]  port_grp3_pins_out,
  output      logic [6:0]  port_grp3_pins_oe,
  output      logic [6:0]  port_grp3_pins_pullup,
  // GPIO settings and read-back
  input  wire logic [7:0]  gpio_data0,
  input  wire logic [7:0]  gpio_dir0,
  input  wire logic [7:0]  gpio_pullup0,
  input  wire logic [6:0]  gpio_data1,
  input  wire logic [6:0]  gpio_dir1,
  input  wire logic [6:0]  gpio_pullup1,
  input  wire logic [6:0]  gpio_data3,
  input  wire logic [6:0]  gpio_dir3,
  input  wire logic [6:0]  gpio_pullup3,
  output      logic [7:0]  gpio_in0,
  output      logic [6:0]  gpio_in1,
  output      logic [6:0]  gpio_in3,
  // External bus configuration
  input  wire logic        ext_bus_en,
  input  wire logic        bus_16bit,
  input  wire logic        wrl_out_en,
  input  wire logic        wrh_out_en,
  input  wire logic        hold_en,
  input  wire logic        ready_en,
  // External bus controller side
  input  wire logic [14:0] muxbus_ad_out,
  input  wire logic        muxbus_ad_oe,
  output      logic [14:0] muxbus_ad_in,
  input  wire logic        bus_ale,
  input  wire logic        bus_read_n,
  input  wire logic        bus_write_strobe_low_n,
  input  wire logic        bus_write_strobe_high_n,
  input  wire logic        bus_hold_ack_n,
  output      logic        bus_hold_request,
  output      logic        bus_ready,
  // Peripherals
  output      logic [7:0]  ext_irq_inputs_8_15,
  output      logic        ext_irq11_alt_in,
  output      logic        ext_irq10_alt_in,
  output      logic        reload_timer1_event_in,
  input  wire logic        reload_timer1_out,
  input  wire logic        timer1_out_en,
  output      logic        serial3_data_in,
  input  wire logic        serial3_data_out,
  input  wire logic        serial3_out_en,
  output      logic        serial3_clock_in,
  input  wire logic        serial3_clock_out,
  input  wire logic        serial3_clock_oe,
  input  wire logic [2:0]  compare_wave_out,
  input  wire logic [2:0]  compare_out_en,
  // Input capture 4 and 5
  input  wire logic [15:0] free_run_count,
  input  wire logic [3:0]  capture_edge_sel,
  output      logic [15:0] capture4_value,
  output      logic [15:0] capture5_value,
  output      logic [1:0]  capture_irq
);

  // Resolves one pin group; returns {oe, out}
  function automatic logic [15:0] pxm_resolve(
    input logic [7:0] own,
    input logic [7:0] bus_oe,
    input logic [7:0] bus_val,
    input logic [7:0] per_en,
    input logic [7:0] per_val,
    input logic [7:0] dir,
    input logic [7:0] dat
  );
    logic [7:0] oe;
    logic [7:0] val;
    oe  = (own & bus_oe) | (~own & (per_en | dir));                // [RULE17]
    val = (own & bus_val) | (~own & ((per_en & per_val) | (~per_en & dat)));
    pxm_resolve = {oe, val};
  endfunction : pxm_resolve

  logic [7:0]  own0;
  logic [6:0]  own1;
  logic [6:0]  own3;
  logic [6:0]  bus_oe3;
  logic [6:0]  bus_val3;
  logic [6:0]  per_en1;
  logic [6:0]  per_val1;
  logic [6:0]  per_en3;
  logic [6:0]  per_val3;
  logic [15:0] next_g0;
  logic [15:0] next_g1;
  logic [15:0] next_g3;
  logic [1:0]  cap_now;
  logic [1:0]  cap_prev;
  logic [1:0]  cap_hit;

  // Pin ownership by the external bus
  always_comb
  begin
    own0 = {8{ext_bus_en}};                                        // [RULE2]
    own1 = {7{ext_bus_en}};                                        // [RULE3]
    own3 = '0;
    own3[pxm_pkg::G3_ALE] = ext_bus_en;                            // [RULE4]
    own3[pxm_pkg::G3_RD]  = ext_bus_en;                            // [RULE5]
    own3[pxm_pkg::G3_WRL] = ext_bus_en & wrl_out_en;               // [RULE6]
    own3[pxm_pkg::G3_WRH] = ext_bus_en & bus_16bit & wrh_out_en;   // [RULE8]
    own3[pxm_pkg::G3_HRQ] = ext_bus_en & hold_en;                  // [RULE9]
    own3[pxm_pkg::G3_HAK] = ext_bus_en & hold_en;                  // [RULE10]
    own3[pxm_pkg::G3_RDY] = ext_bus_en & ready_en;                 // [RULE11]
  end

  // Bus strobes on group 3; request and ready pins are inputs only
  always_comb
  begin
    bus_oe3  = own3;
    bus_oe3[pxm_pkg::G3_HRQ] = 1'b0;
    bus_oe3[pxm_pkg::G3_RDY] = 1'b0;
    bus_val3 = '0;
    bus_val3[pxm_pkg::G3_ALE] = bus_ale;                           // [RULE4]
    bus_val3[pxm_pkg::G3_RD]  = bus_read_n;                        // [RULE5]
    // The controller drives the shared strobe for low or only byte
    bus_val3[pxm_pkg::G3_WRL] = bus_write_strobe_low_n;            // [RULE7]
    bus_val3[pxm_pkg::G3_WRH] = bus_write_strobe_high_n;           // [RULE8]
    bus_val3[pxm_pkg::G3_HAK] = bus_hold_ack_n;                    // [RULE10]
  end

  // Peripheral outputs, used only where the bus does not own the pin
  always_comb
  begin
    per_en1  = '0;
    per_val1 = '0;
    per_en1[pxm_pkg::G1_TMR_OUT]  = timer1_out_en;                 // [RULE13]
    per_val1[pxm_pkg::G1_TMR_OUT] = reload_timer1_out;
    per_en1[pxm_pkg::G1_SER_OUT]  = serial3_out_en;                // [RULE14]
    per_val1[pxm_pkg::G1_SER_OUT] = serial3_data_out;
    per_en1[pxm_pkg::G1_SER_CLK]  = serial3_clock_oe;
    per_val1[pxm_pkg::G1_SER_CLK] = serial3_clock_out;
    per_en3  = {compare_out_en, 4'h0};                             // [RULE15]
    per_val3 = {compare_wave_out, 4'h0};
  end

  always_comb
  begin
    next_g0 = pxm_resolve(own0, {8{muxbus_ad_oe}}, muxbus_ad_out[7:0],
                          8'h00, 8'h00, gpio_dir0, gpio_data0);
    next_g1 = pxm_resolve({1'b0, own1}, {1'b0, {7{muxbus_ad_oe}}},
                          {1'b0, muxbus_ad_out[14:8]}, {1'b0, per_en1},
                          {1'b0, per_val1}, {1'b0, gpio_dir1},
                          {1'b0, gpio_data1});
    next_g3 = pxm_resolve({1'b0, own3}, {1'b0, bus_oe3}, {1'b0, bus_val3},
                          {1'b0, per_en3}, {1'b0, per_val3},
                          {1'b0, gpio_dir3}, {1'b0, gpio_data3});
  end

  // Pad drive; pull-ups only on GPIO inputs, never on bus-owned pins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      port_grp0_pins_out    <= pxm_pkg::RST_PIN;
      port_grp0_pins_oe     <= pxm_pkg::RST_PIN;
      port_grp0_pins_pullup <= pxm_pkg::RST_PIN;
      port_grp1_pins_out    <= pxm_pkg::RST_PIN[6:0];
      port_grp1_pins_oe     <= pxm_pkg::RST_PIN[6:0];
      port_grp1_pins_pullup <= pxm_pkg::RST_PIN[6:0];
      port_grp3_pins_out    <= pxm_pkg::RST_PIN[6:0];
      port_grp3_pins_oe     <= pxm_pkg::RST_PIN[6:0];
      port_grp3_pins_pullup <= pxm_pkg::RST_PIN[6:0];
    end
    else
    begin
      port_grp0_pins_out    <= next_g0[7:0];                       // [RULE2]
      port_grp0_pins_oe     <= next_g0[15:8];
      port_grp0_pins_pullup <= gpio_pullup0 & ~next_g0[15:8]
                               & ~own0; // [RULE1]
      port_grp1_pins_out    <= next_g1[6:0];                       // [RULE3]
      port_grp1_pins_oe     <= next_g1[14:8];
      port_grp1_pins_pullup <= gpio_pullup1 & ~next_g1[14:8]
                               & ~own1; // [RULE1]
      port_grp3_pins_out    <= next_g3[6:0];
      port_grp3_pins_oe     <= next_g3[14:8];
      port_grp3_pins_pullup <= gpio_pullup3 & ~next_g3[14:8]
                               & ~own3; // [RULE1]
    end
  end

  // Pad inputs to GPIO, bus and peripherals; one register stage each
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      gpio_in0               <= pxm_pkg::RST_PIN;
      gpio_in1               <= pxm_pkg::RST_PIN[6:0];
      gpio_in3               <= pxm_pkg::RST_PIN[6:0];
      muxbus_ad_in           <= '0;
      bus_hold_request       <= 1'b0;
      bus_ready              <= pxm_pkg::RST_STROBE;
      ext_irq_inputs_8_15    <= pxm_pkg::RST_PIN;
      ext_irq11_alt_in       <= 1'b0;
      ext_irq10_alt_in       <= 1'b0;
      reload_timer1_event_in <= 1'b0;
      serial3_data_in        <= 1'b0;
      serial3_clock_in       <= 1'b0;
    end
    else
    begin
      gpio_in0               <= port_grp0_pins_in;
      gpio_in1               <= port_grp1_pins_in;
      gpio_in3               <= port_grp3_pins_in;
      muxbus_ad_in           <= {port_grp1_pins_in, port_grp0_pins_in};
      bus_hold_request       <= own3[pxm_pkg::G3_HRQ]            // [RULE9]
                                & port_grp3_pins_in[pxm_pkg::G3_HRQ];
      // Without the ready function the bus never waits
      bus_ready              <= ~own3[pxm_pkg::G3_RDY]           // [RULE11]
                                | port_grp3_pins_in[pxm_pkg::G3_RDY];
      ext_irq_inputs_8_15    <= port_grp0_pins_in;                 // [RULE12]
      ext_irq11_alt_in <= port_grp1_pins_in[pxm_pkg::G1_SER_IN]; // [RULE12]
      ext_irq10_alt_in <= port_grp3_pins_in[pxm_pkg::G3_WRL]; // [RULE12]
      reload_timer1_event_in <=
        port_grp1_pins_in[pxm_pkg::G1_TMR_IN]; // [RULE13]
      serial3_data_in <= port_grp1_pins_in[pxm_pkg::G1_SER_IN]; // [RULE14]
      serial3_clock_in       <= port_grp1_pins_in[pxm_pkg::G1_SER_CLK];
    end
  end

  // Input capture 4 and 5 on group 3 pins 0 and 1
  assign cap_now = {gpio_in3[pxm_pkg::G3_RD], // [RULE15]
                    gpio_in3[pxm_pkg::G3_ALE]};

  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_cap
      assign cap_hit[c] =
        (capture_edge_sel[2*c +: 2] == pxm_pkg::EDGE_RISE
           && cap_now[c] && !cap_prev[c])
        || (capture_edge_sel[2*c +: 2] == pxm_pkg::EDGE_FALL
           && !cap_now[c] && cap_prev[c])
        || (capture_edge_sel[2*c +: 2] == pxm_pkg::EDGE_BOTH
           && (cap_now[c] != cap_prev[c]));                        // [RULE16]
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cap_prev <= 2'h0;
    else
      cap_prev <= cap_now;
  end

  // Count is taken one cycle after the edge reaches gpio_in3
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      capture4_value <= pxm_pkg::RST_CNT;
      capture5_value <= pxm_pkg::RST_CNT;
      capture_irq    <= 2'h0;
    end
    else
    begin
      capture_irq <= cap_hit;                                      // [RULE16]
      if (cap_hit[0])
        capture4_value <= free_run_count;
      if (cap_hit[1])
        capture5_value <= free_run_count;
    end
  end

  // Checks
  property p_grp0_bus;
    @(posedge clk_sys) disable iff (rst)
    ext_bus_en |=> port_grp0_pins_out == $past(muxbus_ad_out[7:0])
                   && port_grp0_pins_oe == {8{$past(muxbus_ad_oe)}};
  endproperty
  a_grp0_bus: assert property (p_grp0_bus) // [RULE2]
    else $error("group 0 not following bus low byte");

  property p_grp1_bus;
    @(posedge clk_sys) disable iff (rst)
    ext_bus_en |=> port_grp1_pins_out == $past(muxbus_ad_out[14:8])
                   && port_grp1_pins_oe == {7{$past(muxbus_ad_oe)}};
  endproperty
  a_grp1_bus: assert property (p_grp1_bus) // [RULE3]
    else $error("group 1 not following bus bits 8-14");

  property p_ale;
    @(posedge clk_sys) disable iff (rst)
    ext_bus_en ##1 ext_bus_en |-> port_grp3_pins_oe[0]
                   && port_grp3_pins_out[0] == $past(bus_ale);
  endproperty
  a_ale: assert property (p_ale) // [RULE4]
    else $error("address latch pin wrong");

  property p_rd;
    @(posedge clk_sys) disable iff (rst)
    ext_bus_en |=> port_grp3_pins_oe[1]
                   && port_grp3_pins_out[1] == $past(bus_read_n);
  endproperty
  a_rd: assert property (p_rd) // [RULE5]
    else $error("read strobe pin wrong");

  property p_wrl_gpio;
    @(posedge clk_sys) disable iff (rst)
    !(ext_bus_en && wrl_out_en)
      |=> port_grp3_pins_oe[2] == $past(gpio_dir3[2])
          && port_grp3_pins_out[2] == $past(gpio_data3[2]);
  endproperty
  a_wrl_gpio: assert property (p_wrl_gpio) // [RULE6]
    else $error("write strobe pin not GPIO when disabled");

  property p_wrh;
    @(posedge clk_sys) disable iff (rst)
    (ext_bus_en && bus_16bit && wrh_out_en)
      |=> port_grp3_pins_oe[3]
          && port_grp3_pins_out[3] == $past(bus_write_strobe_high_n);
  endproperty
  a_wrh: assert property (p_wrh) // [RULE8]
    else $error("high write strobe pin wrong");

  property p_hak;
    @(posedge clk_sys) disable iff (rst)
    !(ext_bus_en && hold_en) |=> !bus_hold_request
      && port_grp3_pins_oe[5]
         == ($past(gpio_dir3[5]) || $past(compare_out_en[1]));
  endproperty
  a_hak: assert property (p_hak) // [RULE10]
    else $error("hold pins active while hold disabled");

  property p_ready;
    @(posedge clk_sys) disable iff (rst)
    !(ext_bus_en && ready_en) |=> bus_ready;
  endproperty
  a_ready: assert property (p_ready) // [RULE11]
    else $error("ready taken while function disabled");

  property p_pullup;
    @(posedge clk_sys) disable iff (rst)
    !ext_bus_en |=> port_grp0_pins_pullup
                    == ($past(gpio_pullup0) & ~$past(gpio_dir0));
  endproperty
  a_pullup: assert property (p_pullup) // [RULE1]
    else $error("group 0 pull-up wrong");

  property p_irq_route;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> ext_irq_inputs_8_15 == $past(port_grp0_pins_in);
  endproperty
  a_irq_route: assert property (p_irq_route) // [RULE12]
    else $error("interrupt inputs not routed from group 0");

  property p_capture;
    @(posedge clk_sys) disable iff (rst)
    (capture_edge_sel[1:0] == pxm_pkg::EDGE_RISE
     && cap_now[0] && !cap_prev[0])
      |=> capture_irq[0] && capture4_value == $past(free_run_count);
  endproperty
  a_capture: assert property (p_capture) // [RULE16]
    else $error("capture 4 missed rising edge");

endmodule : pxm_pin_mux

// ==== pxm_ext_mem_model.sv ====
// External memory on the multiplexed address/data bus, and the pad
// resolution of every pin of groups 0, 1 and 3.
// Assumes the multiplexer's registered pad outputs and one clock, clk_sys.
`timescale 1ns/100ps
module pxm_ext_mem_model (
  // Clock
  input  wire logic        clk_sys,
  // Pad drive from the multiplexer
  input  wire logic [7:0]  port_grp0_pins_out,
  input  wire logic [7:0]  port_grp0_pins_oe,
  input  wire logic [7:0]  port_grp0_pins_pullup,
  input  wire logic [6:0]  port_grp1_pins_out,
  input  wire logic [6:0]  port_grp1_pins_oe,
  input  wire logic [6:0]  port_grp1_pins_pullup,
  input  wire logic [6:0]  port_grp3_pins_out,
  input  wire logic [6:0]  port_grp3_pins_oe,
  input  wire logic [6:0]  port_grp3_pins_pullup,
  // Pad levels seen by the multiplexer
  output      logic [7:0]  port_grp0_pins_in,
  output      logic [6:0]  port_grp1_pins_in,
  output      logic [6:0]  port_grp3_pins_in,
  // Bench drive of free pins, hold request and ready level
  input  wire logic [21:0] tb_oe,
  input  wire logic [21:0] tb_val,
  input  wire logic        hold_req,
  input  wire logic        ready_lvl
);
  logic [21:0] d_out, d_oe, d_pu, m_oe, m_val, pad;
  logic [14:0] addr;
  logic [14:0] mem [0:15];
  logic        rd_act;
  logic        flt = 1'b0;

  assign d_out = {port_grp3_pins_out, port_grp1_pins_out, port_grp0_pins_out};
  assign d_oe  = {port_grp3_pins_oe, port_grp1_pins_oe, port_grp0_pins_oe};
  assign d_pu  = {port_grp3_pins_pullup, port_grp1_pins_pullup,
                  port_grp0_pins_pullup};
  // Data answered on all 15 lines while the read strobe is low
  assign rd_act = d_oe[16] & ~d_out[16];
  assign m_oe  = {1'b1, 1'b0, 1'b1, 4'h0, {15{rd_act}}};
  assign m_val = {ready_lvl, 1'b0, hold_req, 4'h0, mem[addr[3:0]]};
  // Released lines show the pull-up or a level that toggles every cycle
  assign pad = (d_oe & d_out) | (~d_oe & m_oe & m_val)
             | (~d_oe & ~m_oe & tb_oe & tb_val)
             | (~d_oe & ~m_oe & ~tb_oe & (d_pu | {22{flt}}));
  assign port_grp0_pins_in = pad[7:0];
  assign port_grp1_pins_in = pad[14:8];
  assign port_grp3_pins_in = pad[21:15];

  always @(posedge clk_sys)
  begin
    flt <= ~flt;
  end

  // Address latched during the strobe, bytes written while strobes are low
  always_ff @(posedge clk_sys)
  begin
    if (d_oe[15] && d_out[15])
      addr <= d_out[14:0];
    if (d_oe[17] && !d_out[17])
      mem[addr[3:0]][7:0] <= d_out[7:0];
    if (d_oe[18] && !d_out[18])
      mem[addr[3:0]][14:8] <= d_out[14:8];
  end
endmodule : pxm_ext_mem_model

// ==== test_port_external_bus_pin_mux.sv ====
// Self-checking bench for the port and external-bus pin multiplexer.
// Assumes pxm_pin_mux and the external memory model pxm_ext_mem_model.
`timescale 1ns/100ps
module test_port_external_bus_pin_mux;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  port_grp0_pins_in, port_grp0_pins_out, port_grp0_pins_oe,
               port_grp0_pins_pullup, gpio_data0, gpio_dir0, gpio_pullup0,
               gpio_in0, ext_irq_inputs_8_15;
  logic [6:0]  port_grp1_pins_in, port_grp1_pins_out, port_grp1_pins_oe,
               port_grp1_pins_pullup, gpio_data1, gpio_dir1, gpio_pullup1,
               gpio_in1, port_grp3_pins_in, port_grp3_pins_out,
               port_grp3_pins_oe, port_grp3_pins_pullup, gpio_data3,
               gpio_dir3, gpio_pullup3, gpio_in3;
  logic        ext_bus_en, bus_16bit, wrl_out_en, wrh_out_en, hold_en,
               ready_en, muxbus_ad_oe, bus_ale, bus_read_n, bus_hold_ack_n,
               bus_write_strobe_low_n, bus_write_strobe_high_n, bus_ready,
               bus_hold_request, ext_irq11_alt_in, ext_irq10_alt_in,
               reload_timer1_event_in, reload_timer1_out, timer1_out_en,
               serial3_data_in, serial3_data_out, serial3_out_en,
               serial3_clock_in, serial3_clock_out, serial3_clock_oe;
  logic [14:0] muxbus_ad_out, muxbus_ad_in;
  logic [2:0]  compare_wave_out, compare_out_en;
  logic [15:0] free_run_count, capture4_value, capture5_value;
  logic [3:0]  capture_edge_sel;
  logic [1:0]  capture_irq;
  logic [21:0] tb_oe, tb_val;
  logic        hold_req, ready_lvl;
  int          errors = 0, n_compared = 0, cycles = 0;

  pxm_pin_mux uut (
    .clk_sys, .rst, .port_grp0_pins_in, .port_grp0_pins_out,
    .port_grp0_pins_oe, .port_grp0_pins_pullup, .port_grp1_pins_in,
    .port_grp1_pins_out, .port_grp1_pins_oe, .port_grp1_pins_pullup,
    .port_grp3_pins_in, .port_grp3_pins_out, .port_grp3_pins_oe,
    .port_grp3_pins_pullup, .gpio_data0, .gpio_dir0, .gpio_pullup0,
    .gpio_data1, .gpio_dir1, .gpio_pullup1, .gpio_data3, .gpio_dir3,
    .gpio_pullup3, .gpio_in0, .gpio_in1, .gpio_in3, .ext_bus_en, .bus_16bit,
    .wrl_out_en, .wrh_out_en, .hold_en, .ready_en, .muxbus_ad_out,
    .muxbus_ad_oe, .muxbus_ad_in, .bus_ale, .bus_read_n,
    .bus_write_strobe_low_n, .bus_write_strobe_high_n, .bus_hold_ack_n,
    .bus_hold_request, .bus_ready, .ext_irq_inputs_8_15, .ext_irq11_alt_in,
    .ext_irq10_alt_in, .reload_timer1_event_in, .reload_timer1_out,
    .timer1_out_en, .serial3_data_in, .serial3_data_out, .serial3_out_en,
    .serial3_clock_in, .serial3_clock_out, .serial3_clock_oe,
    .compare_wave_out, .compare_out_en, .free_run_count, .capture_edge_sel,
    .capture4_value, .capture5_value, .capture_irq
  );

  pxm_ext_mem_model mdl (
    .clk_sys, .port_grp0_pins_out, .port_grp0_pins_oe, .port_grp0_pins_pullup,
    .port_grp1_pins_out, .port_grp1_pins_oe, .port_grp1_pins_pullup,
    .port_grp3_pins_out, .port_grp3_pins_oe, .port_grp3_pins_pullup,
    .port_grp0_pins_in, .port_grp1_pins_in, .port_grp3_pins_in,
    .tb_oe, .tb_val, .hold_req, .ready_lvl
  );

  always #2.5 clk_sys = ~clk_sys;

  // Generous ceiling: the whole run needs well under 300 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Inputs change only just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic set_idle();
    {gpio_data0, gpio_dir0, gpio_pullup0} = '0;
    {gpio_data1, gpio_dir1, gpio_pullup1, gpio_data3, gpio_dir3} = '0;
    gpio_pullup3 = '0;
    {ext_bus_en, bus_16bit, wrl_out_en, wrh_out_en, hold_en, ready_en} = '0;
    {muxbus_ad_out, muxbus_ad_oe, bus_ale} = '0;
    {bus_read_n, bus_write_strobe_low_n, bus_write_strobe_high_n} = 3'h7;
    bus_hold_ack_n = 1'b1;
    {reload_timer1_out, timer1_out_en, serial3_data_out, serial3_out_en} = '0;
    {serial3_clock_out, serial3_clock_oe, compare_wave_out} = '0;
    compare_out_en = '0;
    {free_run_count, capture_edge_sel, tb_oe, tb_val, hold_req} = '0;
    ready_lvl = 1'b1;
  endtask : set_idle

  task automatic t_gpio();
    set_idle();
    gpio_dir0 = 8'hf0;
    gpio_data0 = 8'ha5;
    gpio_pullup0 = 8'hff;
    tb_oe[7:0] = 8'h0f;
    tb_val[7:0] = 8'h06;
    step(2);
    chk("grp0 oe", 16'h00f0, port_grp0_pins_oe);
    chk("grp0 out", 16'h00a0, port_grp0_pins_out & 8'hf0);
    chk("grp0 pullup", 16'h000f, port_grp0_pins_pullup);
    chk("grp0 read", 16'h00a6, gpio_in0);
    chk("irq 8 to 15", 16'h00a6, ext_irq_inputs_8_15);
    gpio_pullup0 = 8'h05;
    step(1);
    chk("pullup off", 16'h0005, port_grp0_pins_pullup);
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_periph();
    set_idle();
    {timer1_out_en, reload_timer1_out, serial3_out_en} = 3'h7;
    {serial3_data_out, serial3_clock_oe, serial3_clock_out} = 3'h7;
    compare_out_en = 3'h7;
    compare_wave_out = 3'h5;
    gpio_dir1 = 7'h62;
    tb_oe[17:8] = 10'h205;
    tb_val[17:8] = 10'h205;
    step(2);
    chk("grp1 oe", 16'h007a, port_grp1_pins_oe);
    chk("grp1 out", 16'h001a, port_grp1_pins_out & 7'h1e);
    chk("grp3 cmp oe", 16'h0070, port_grp3_pins_oe & 7'h70);
    chk("grp3 cmp", 16'h0050, port_grp3_pins_out & 7'h70);
    chk("timer ev", 16'h0001, reload_timer1_event_in);
    chk("ser in", 16'h0001, serial3_data_in);
    chk("ser clk", 16'h0001, serial3_clock_in);
    chk("grp1 read", 16'h001f, gpio_in1);
    chk("alt irq", 16'h0003, {ext_irq11_alt_in, ext_irq10_alt_in});
    $display("test peripherals done");
  endtask : t_periph

  // Address phase with the address latch pulse
  task automatic bus_addr(input logic [14:0] a);
    bus_ale = 1'b1;
    muxbus_ad_oe = 1'b1;
    muxbus_ad_out = a;
    step(1);
    chk("ad low", {8'h00, a[7:0]}, port_grp0_pins_out);
    chk("ad high", {9'h000, a[14:8]}, port_grp1_pins_out);
    chk("latch pin", 16'h0001, port_grp3_pins_out[0]);
    chk("ad oe", 16'h7fff, {port_grp1_pins_oe, port_grp0_pins_oe});
    bus_ale = 1'b0;
  endtask : bus_addr

  task automatic bus_write(input logic [14:0] a, input logic [14:0] d,
                           input logic wide);
    bus_addr(a);
    muxbus_ad_out = d;
    bus_write_strobe_low_n = 1'b0;
    bus_write_strobe_high_n = ~wide;
    step(1);
    chk("strobes", {12'h000, ~wide, 3'h2}, port_grp3_pins_out[3:0]);
    bus_write_strobe_low_n = 1'b1;
    bus_write_strobe_high_n = 1'b1;
    step(1);
    muxbus_ad_oe = 1'b0;
    step(1);
  endtask : bus_write

  task automatic t_bus();
    set_idle();
    {ext_bus_en, bus_16bit, wrl_out_en, wrh_out_en} = 4'hf;
    gpio_dir0 = 8'hff;
    gpio_data0 = 8'h00;
    gpio_data3 = 7'h08;
    bus_write(15'h5a03, 15'h3c96, 1'b1);
    chk("word", 16'h3c96, mdl.mem[3]);
    bus_16bit = 1'b0;
    bus_write(15'h0004, 15'h29c3, 1'b0);
    chk("byte", 16'h00c3, mdl.mem[4][7:0]);
    bus_16bit = 1'b1;
    bus_addr(15'h2a03);
    muxbus_ad_oe = 1'b0;
    bus_read_n = 1'b0;
    step(2);
    chk("read pin", 16'h0000, port_grp3_pins_out[1]);
    chk("released", 16'h0000, port_grp0_pins_oe);
    chk("read data", 16'h3c96, muxbus_ad_in);
    $display("test bus done");
  endtask : t_bus

  task automatic t_own();
    set_idle();
    for (int i = 0; i < 16; i++)
    begin
      {ext_bus_en, bus_16bit, wrl_out_en, wrh_out_en} = i[3:0];
      {hold_en, ready_en, hold_req, ready_lvl} = i[3:0];
      bus_hold_ack_n = 1'b0;
      step(2);
      chk("strobe oe", {14'h0, i[3] & i[2] & i[0], i[3] & i[1]},
          port_grp3_pins_oe[3:2]);
      chk("hold req", i[3] & i[1], bus_hold_request);
      chk("hold ack oe", i[3], port_grp3_pins_oe[5]);
      chk("ready", {~(i[3] & i[2]) | i[0]}, bus_ready);
      chk("ready pin oe", 16'h0000, port_grp3_pins_oe[6]);
    end
    $display("test ownership done");
  endtask : t_own

  task automatic t_capture();
    set_idle();
    tb_oe[16:15] = 2'b11;
    for (int c = 0; c < 4; c++)
    begin
      capture_edge_sel = {c[1:0], c[1:0]};
      tb_val[16:15] = 2'b00;
      step(3);
      free_run_count = 16'h1000 + 16'(c);
      tb_val[16:15] = 2'b11;
      step(2);
      chk("rise irq", {14'h0, {2{c[0]}}}, capture_irq);
      if (c[0])
        chk("rise value", 16'h1000 + 16'(c), capture5_value);
      step(1);
      chk("irq pulse", 16'h0000, capture_irq);
      free_run_count = 16'h2000 + 16'(c);
      tb_val[16:15] = 2'b00;
      step(2);
      chk("fall irq", {14'h0, {2{c[1]}}}, capture_irq);
      if (c[1])
        chk("fall value", 16'h2000 + 16'(c), capture4_value);
    end
    $display("test capture done");
  endtask : t_capture

  initial
  begin
    set_idle();
    step(3);
    rst = 1'b0;
    t_gpio();
    t_periph();
    t_bus();
    t_own();
    t_capture();
    tally_and_finish();
  end
endmodule : test_port_external_bus_pin_mux
